// file: verilog/loader_access_pkg.sv
// Constants for the loader region access control block: register map, field
// positions, command and error codes, context encodings and reset values.
// Assumes a 32-bit AXI4-Lite register bus and byte addressing.
`default_nettype none
package loader_access_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_RESULT = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0C;
  localparam logic [7:0] ADDR_STATE = 8'h10;
  localparam logic [7:0] ADDR_PASSWORD = 8'h14;
  localparam logic [7:0] ADDR_LOCK = 8'h18;

  localparam logic [1:0] SYSTEM_REGION_CTX = 2'h0;
  localparam logic [1:0] LOADER_REGION_CTX = 2'h1;
  localparam logic [1:0] APPLICATION_REGION_CTX = 2'h2;

  localparam logic [7:0] CMD_STATUS = 8'h00;
  localparam logic [7:0] CMD_UNLOCK = 8'h10;
  localparam logic [7:0] CMD_PROTECTED_ACCESS = 8'h20;
  localparam logic [7:0] CMD_MASTER_ERASE = 8'h30;
  localparam logic [7:0] READ_REGION_CONTEXT_CMD = 8'hF0;
  localparam logic [7:0] WRITE_REGION_CONTEXT_CMD = 8'hF1;
  localparam logic [7:0] CMD_ERASE_SYSTEM = 8'hF2;
  localparam logic [7:0] CMD_ERASE_LOADER = 8'hF3;

  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_BAD_CONTEXT = 8'h01;
  localparam logic [7:0] ERR_LOCKED = 8'h02;
  localparam logic [7:0] ERR_UNKNOWN_CMD = 8'h03;
  localparam logic [7:0] ERR_NO_MATCH = 8'h04;

  localparam int ARG_LSB = 8;
  localparam int ERR_LSB = 8;
  localparam int LOCK_LSB = 4;
  localparam int PROT_BIT = 8;
  localparam int DBG_LOCK_BIT = 9;
  localparam int DBG_EN_BIT = 10;
  localparam int RUN_BIT = 11;

  localparam int EV_W = 3;
  localparam int EV_DONE = 0;
  localparam int EV_ERROR = 1;
  localparam int EV_ERASE = 2;

  localparam logic [2:0] LOCK_RESET = 3'h7;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage
`default_nettype wire

// file: verilog/pin_sync.sv
// Three-stage synchroniser for a level from outside the clock domain.
// The output follows once the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic pin,
  output logic level
);
  logic stage1;
  logic stage2;
  logic stage3;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      level <= 1'b0;
    end else if (stage2 == stage3) begin
      level <= stage3;
    end
  end
endmodule
`default_nettype wire

// file: verilog/event_flags.sv
// Sticky event flags, write-one-to-clear, with a mask and one level interrupt.
// Assumes events and clears arrive as one-cycle pulses on the same clock.
`timescale 1ns/1ps
`default_nettype none
module event_flags #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] events,
  input wire logic [W-1:0] clearBits,
  input wire logic writeMask,
  input wire logic [W-1:0] maskValue,
  output logic [W-1:0] status,
  output logic [W-1:0] mask,
  output logic irq
);
  logic [W-1:0] next_status;

  // A new event beats a clear in the same cycle
  assign next_status = (status & ~clearBits) | events;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mask <= '0;
    end else if (writeMask) begin
      mask <= maskValue;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status & (writeMask ? maskValue : mask));
    end
  end
endmodule
`default_nettype wire

// file: verilog/loader_region_access_control.sv
// Region context and password lock control for the code memory loader.
// Commands arrive as writes to the command register over AXI4-Lite; region
// presence, passwords and the debug word come from code memory and must be
// stable while configReady is high. configReady is an asynchronous pin.
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module loader_region_access_control #(
  parameter int PW_W = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [loader_access_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [loader_access_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic configReady,
  input wire logic loaderPresent,
  input wire logic applicationPresent,
  input wire logic [PW_W-1:0] systemPassword,
  input wire logic [PW_W-1:0] loaderPassword,
  input wire logic [PW_W-1:0] applicationPassword,
  input wire logic [15:0] debugLockWord,
  input wire logic utilityRomActive,
  output logic irq,
  output logic protection_enable_bit,
  output logic debug_lockout_bit,
  output logic debugEnable,
  output logic eraseStart,
  output logic [1:0] eraseBaseRegion,
  output logic accessGrant,
  output logic [1:0] accessScope
);
  import loader_access_pkg::*;

  generate
    if (PW_W < 1 || PW_W > 32) begin : g_bad_width
      $error("PW_W must lie between 1 and 32");
    end
  endgenerate

  typedef enum logic {PH_WAIT, PH_RUN} phase_type;

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = (a == ADDR_CMD) || (a == ADDR_RESULT) || (a == ADDR_STATUS) ||
               (a == ADDR_MASK) || (a == ADDR_STATE) || (a == ADDR_PASSWORD) ||
               (a == ADDR_LOCK);
  endfunction

  function automatic logic [31:0] applyStrobe(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = data[8*i +: 8];
      end
    end
    applyStrobe = r;
  endfunction

  function automatic logic [PW_W-1:0] regionPassword(input logic [1:0] c,
                                                     input logic [PW_W-1:0] s,
                                                     input logic [PW_W-1:0] l,
                                                     input logic [PW_W-1:0] a);
    case (c)
      LOADER_REGION_CTX: regionPassword = l;
      APPLICATION_REGION_CTX: regionPassword = a;
      default: regionPassword = s;
    endcase
  endfunction

  logic awHeld, wHeld, next_awHeld, next_wHeld, next_bvalid, next_rvalid, doWrite;
  logic cfgLevel, startDone, cmdFire, argValid, pwMatch, defaultBlank;
  logic [ADDR_W-1:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  phase_type phase;
  logic [1:0] regionCtx, defaultCtx;
  logic [2:0] password_lock_bits;
  logic [PW_W-1:0] suppliedPassword, blankPw;
  logic [7:0] resultByte, errorCode, cmdCode, cmdArg;
  logic [EV_W-1:0] events, evStatus, evMask, clearBits;

  assign blankPw = '1;
  assign doWrite = awHeld && wHeld && !bvalid;
  assign startDone = (phase == PH_WAIT) && cfgLevel;
  assign cmdFire = doWrite && (awAddr == ADDR_CMD) && wStrb[0] && (phase == PH_RUN);
  assign cmdCode = wData[7:0];
  assign cmdArg = wData[ARG_LSB +: 8];
  // An encoding is accepted only if that region really exists
  assign argValid = (cmdArg == 8'(SYSTEM_REGION_CTX)) ||
                    (cmdArg == 8'(LOADER_REGION_CTX) && loaderPresent) ||
                    (cmdArg == 8'(APPLICATION_REGION_CTX) && applicationPresent);
  assign pwMatch = suppliedPassword ==
                   regionPassword(regionCtx, systemPassword, loaderPassword, applicationPassword);
  assign defaultCtx = applicationPresent ? APPLICATION_REGION_CTX :
                      loaderPresent ? LOADER_REGION_CTX : SYSTEM_REGION_CTX;
  assign defaultBlank = regionPassword(defaultCtx, systemPassword, loaderPassword,
                                       applicationPassword) == blankPw;
  assign clearBits = (doWrite && awAddr == ADDR_STATUS && wStrb[0]) ? wData[EV_W-1:0] : '0;

  pin_sync u_cfg_sync (
    .clk(clk),
    .reset(reset),
    .pin(configReady),
    .level(cfgLevel)
  );

  event_flags #(.W(EV_W)) u_flags (
    .clk(clk),
    .reset(reset),
    .events(events),
    .clearBits(clearBits),
    .writeMask(doWrite && awAddr == ADDR_MASK),
    .maskValue(EV_W'(applyStrobe(32'(evMask), wData, wStrb))),
    .status(evStatus),
    .mask(evMask),
    .irq(irq)
  );

  // Bus write side: address and data are taken in either order
  always_comb begin
    next_awHeld = awHeld || (awvalid && awready);
    next_wHeld = wHeld || (wvalid && wready);
    if (doWrite) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
    end
    next_bvalid = bvalid ? !bready : doWrite;
    next_rvalid = rvalid ? !rready : (arvalid && arready);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= AXI_OKAY;
      awAddr <= '0;
      wData <= '0;
      wStrb <= '0;
    end else begin
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      bvalid <= next_bvalid;
      awready <= !next_awHeld && !next_bvalid;
      wready <= !next_wHeld && !next_bvalid;
      if (awvalid && awready) begin
        awAddr <= awaddr;
      end
      if (wvalid && wready) begin
        wData <= wdata;
        wStrb <= wstrb;
      end
      if (doWrite) begin
        bresp <= isMapped(awAddr) ? AXI_OKAY : AXI_SLVERR;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= AXI_OKAY;
    end else begin
      rvalid <= next_rvalid;
      arready <= !next_rvalid;
      if (arvalid && arready) begin
        rresp <= isMapped(araddr) ? AXI_OKAY : AXI_SLVERR;
        case (araddr)
          ADDR_RESULT: rdata <= {16'h0000, errorCode, resultByte};
          ADDR_STATUS: rdata <= 32'(evStatus);
          ADDR_MASK: rdata <= 32'(evMask);
          ADDR_STATE: rdata <= 32'({phase == PH_RUN, debugEnable, debug_lockout_bit,
                                    protection_enable_bit, 1'b0, password_lock_bits,
                                    2'h0, regionCtx});
          default: rdata <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase <= PH_WAIT;
    end else if (startDone) begin
      phase <= PH_RUN;
    end
  end

  // Startup settings: protection and debug lockout
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      protection_enable_bit <= 1'b1;
      debug_lockout_bit <= 1'b0;
      debugEnable <= 1'b0;
    end else begin
      if (startDone) begin
        protection_enable_bit <= systemPassword != blankPw;
        debug_lockout_bit <= debugLockWord != ERASED_WORD;
      end
      debugEnable <= !protection_enable_bit && !debug_lockout_bit;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      suppliedPassword <= '0;
    end else if (doWrite && awAddr == ADDR_PASSWORD) begin
      suppliedPassword <= PW_W'(applyStrobe(32'(suppliedPassword), wData, wStrb));
    end
  end

  // Lock bits: a context write command never retests the new region; only startup tests the default one
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      password_lock_bits <= LOCK_RESET;
    end else if (startDone) begin
      password_lock_bits[defaultCtx] <= !defaultBlank;
    end else if (cmdFire && cmdCode == CMD_UNLOCK) begin
      password_lock_bits[regionCtx] <= !pwMatch;
    end else if (doWrite && awAddr == ADDR_LOCK && wStrb[0]) begin
      password_lock_bits[APPLICATION_REGION_CTX] <= wData[APPLICATION_REGION_CTX];
      if (utilityRomActive) begin
        password_lock_bits[1:0] <= wData[1:0];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      regionCtx <= SYSTEM_REGION_CTX;
    end else if (startDone) begin
      regionCtx <= defaultCtx;
    end else if (cmdFire && cmdCode == WRITE_REGION_CONTEXT_CMD && argValid) begin
      regionCtx <= cmdArg[1:0];
    end
  end

  // Command results; family 0 commands and the F2 and F3 erases never look at the context
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      resultByte <= '0;
      errorCode <= ERR_NONE;
      eraseStart <= 1'b0;
      eraseBaseRegion <= SYSTEM_REGION_CTX;
      accessGrant <= 1'b0;
      accessScope <= SYSTEM_REGION_CTX;
      events <= '0;
    end else begin
      eraseStart <= 1'b0;
      accessGrant <= 1'b0;
      events <= '0;
      if (cmdFire) begin
        events[EV_DONE] <= 1'b1;
        errorCode <= ERR_NONE;
        case (cmdCode)
          CMD_STATUS: begin
            resultByte <= errorCode;
            errorCode <= errorCode;
          end
          READ_REGION_CONTEXT_CMD: resultByte <= 8'(regionCtx);
          WRITE_REGION_CONTEXT_CMD: begin
            if (!argValid) begin
              errorCode <= ERR_BAD_CONTEXT;
              events[EV_ERROR] <= 1'b1;
            end
          end
          CMD_UNLOCK: begin
            if (!pwMatch) begin
              errorCode <= ERR_NO_MATCH;
              events[EV_ERROR] <= 1'b1;
            end
          end
          CMD_PROTECTED_ACCESS: begin
            if (password_lock_bits[regionCtx]) begin
              errorCode <= ERR_LOCKED;
              events[EV_ERROR] <= 1'b1;
            end else begin
              accessGrant <= 1'b1;
              accessScope <= regionCtx;
            end
          end
          CMD_MASTER_ERASE: begin
            eraseStart <= 1'b1;
            eraseBaseRegion <= regionCtx;
            events[EV_ERASE] <= 1'b1;
          end
          CMD_ERASE_SYSTEM, CMD_ERASE_LOADER: begin
            eraseStart <= 1'b1;
            eraseBaseRegion <= (cmdCode == CMD_ERASE_SYSTEM) ? SYSTEM_REGION_CTX :
                               LOADER_REGION_CTX;
            events[EV_ERASE] <= 1'b1;
          end
          default: begin
            errorCode <= ERR_UNKNOWN_CMD;
            events[EV_ERROR] <= 1'b1;
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_GET_CTX: assert property (
    cmdFire && cmdCode == READ_REGION_CONTEXT_CMD |=> resultByte == 8'($past(regionCtx))
  ) else $error("context read returned wrong byte");
  AST_BAD_CTX: assert property (
    cmdFire && cmdCode == WRITE_REGION_CONTEXT_CMD && !argValid
    |=> $stable(regionCtx) && errorCode != ERR_NONE
  ) else $error("bad context byte changed context or left no error");
  AST_SET_CTX: assert property (
    cmdFire && cmdCode == WRITE_REGION_CONTEXT_CMD && argValid
    |=> regionCtx == $past(cmdArg[1:0]) && errorCode == ERR_NONE
  ) else $error("context write not applied");
  AST_DEFAULT: assert property (
    startDone |=> regionCtx == $past(defaultCtx) && phase == PH_RUN
  ) else $error("default context wrong at startup");
  AST_LOCK_GUARD: assert property (
    cmdFire && cmdCode == CMD_PROTECTED_ACCESS && password_lock_bits[regionCtx]
    |=> !accessGrant ##1 !accessGrant
  ) else $error("access granted to locked region");
  AST_ERASE_BASE: assert property (
    cmdFire && cmdCode == CMD_MASTER_ERASE |=> eraseStart && eraseBaseRegion == $past(regionCtx)
  ) else $error("master erase base wrong");
  AST_ERASE_GLOBAL: assert property (
    cmdFire && cmdCode == CMD_ERASE_SYSTEM |=> eraseStart && eraseBaseRegion == SYSTEM_REGION_CTX
  ) else $error("system erase depends on context");
  AST_DBG_OFF: assert property (
    protection_enable_bit |=> !debugEnable
  ) else $error("debug enabled while protected");
  AST_ROM_ONLY: assert property (
    doWrite && awAddr == ADDR_LOCK && !utilityRomActive && !startDone && !cmdFire
    |=> password_lock_bits[1:0] == $past(password_lock_bits[1:0])
  ) else $error("system or loader lock written outside utility ROM");
  AST_UNLOCK: assert property (
    cmdFire && cmdCode == CMD_UNLOCK && pwMatch |=> !password_lock_bits[$past(regionCtx)]
  ) else $error("matching password left region locked");

  COV_SET_CTX: cover property (cmdFire && cmdCode == WRITE_REGION_CONTEXT_CMD
                               ##1 !events[EV_ERROR]);
  COV_GRANT: cover property (accessGrant);
  COV_ERASE: cover property (eraseStart && eraseBaseRegion == APPLICATION_REGION_CTX);
endmodule
`default_nettype wire

// file: tb/code_image_model.sv
// Code memory image that the loader reads at startup: passwords and ready.
// Assumes the bench picks which passwords are blank before each reset.
`timescale 1ns/1ps
`default_nettype none
module code_image_model #(
  parameter int PW_W = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] blank,
  output logic configReady,
  output logic [PW_W-1:0] systemPassword,
  output logic [PW_W-1:0] loaderPassword,
  output logic [PW_W-1:0] applicationPassword
);
  int cnt;
  // Ready rises off the clock edge, as an unsynchronised pin would
  always @(negedge clk or posedge reset) begin
    if (reset) begin
      cnt <= 0;
      configReady <= 1'b0;
    end else if (cnt < 4) begin
      cnt <= cnt + 1;
    end else begin
      configReady <= 1'b1;
    end
  end
  // All ones marks a blank password
  assign systemPassword = blank[0] ? '1 : PW_W'(16'h5A00);
  assign loaderPassword = blank[1] ? '1 : PW_W'(16'h5A01);
  assign applicationPassword = blank[2] ? '1 : PW_W'(16'h5A02);
endmodule
`default_nettype wire

// file: tb/loader_region_access_control_bench.sv
// Self-checking bench for the loader region access control block.
// Assumes the package constants and the code image model at the far side.
`timescale 1ns/1ps
`default_nettype none
module loader_region_access_control_bench;
  import loader_access_pkg::*;
  localparam int PW_W = 16;
  logic clk, reset, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, configReady, loaderPresent;
  logic applicationPresent, utilityRomActive, irq, protection_enable_bit;
  logic debug_lockout_bit, debugEnable, eraseStart, accessGrant;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, eraseBaseRegion, accessScope, rs, ctx, lastBase, lastScope;
  logic [PW_W-1:0] systemPassword, loaderPassword, applicationPassword;
  logic [15:0] debugLockWord;
  logic [7:0] v;
  logic [2:0] blank, locks;
  int num_errors, checks_done, erases, grants;

  loader_region_access_control #(.PW_W(PW_W)) i_loader_region_access_control (
    .clk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .configReady, .loaderPresent, .applicationPresent, .systemPassword,
    .loaderPassword, .applicationPassword, .debugLockWord, .utilityRomActive, .irq,
    .protection_enable_bit, .debug_lockout_bit, .debugEnable, .eraseStart,
    .eraseBaseRegion, .accessGrant, .accessScope
  );
  code_image_model #(.PW_W(PW_W)) i_code_image_model (
    .clk, .reset, .blank, .configReady, .systemPassword, .loaderPassword,
    .applicationPassword
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Pulses last one cycle, so count them as they pass
  always @(posedge clk) begin
    if (eraseStart === 1'b1) begin
      erases <= erases + 1;
      lastBase <= eraseBaseRegion;
    end
    if (accessGrant === 1'b1) begin
      grants <= grants + 1;
      lastScope <= accessScope;
    end
  end

  task automatic complete_run();
    $display("Mismatches %0d, checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    rs = bresp;
    bready <= 1'b0;
    if (n >= 100) num_errors++;
  endtask

  task automatic axr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (n >= 100) num_errors++;
  endtask

  // Effects land on the same edge as the response, flags one edge later
  task automatic cmd(input logic [7:0] code, input logic [7:0] arg);
    axw(ADDR_CMD, {16'h0, arg, code});
    repeat (2) @(posedge clk);
  endtask

  function automatic logic [31:0] expState(input logic [1:0] c, input logic [2:0] lk,
      input logic p, input logic l);
    return {20'h0, 1'b1, ~p & ~l, l, p, 1'b0, lk, 2'h0, c};
  endfunction

  task automatic boot(input logic l, input logic a, input logic [2:0] b,
      input logic [15:0] w);
    int n;
    @(posedge clk);
    reset <= 1'b1;
    {loaderPresent, applicationPresent, blank, debugLockWord} <= {l, a, b, w};
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    ctx = a ? APPLICATION_REGION_CTX : {1'b0, l};
    locks = 3'h7 & ~(3'(b[ctx]) << ctx);
    n = 0;
    do begin
      axr(ADDR_STATE);
      n++;
    end while (rd[RUN_BIT] !== 1'b1 && n < 50);
    // Debug enable trails the run bit by one edge, so read once more
    axr(ADDR_STATE);
    chk(rd & 32'hF73, expState(ctx, locks, ~b[0], w != ERASED_WORD));
    rd = {29'h0, ~b[0], w != ERASED_WORD, b[0] && w == ERASED_WORD};
    chk(32'({protection_enable_bit, debug_lockout_bit, debugEnable}), rd);
  endtask

  task automatic tryRegion(input logic [1:0] c, input logic [PW_W-1:0] pw, input logic ok);
    int g;
    cmd(WRITE_REGION_CONTEXT_CMD, 8'(c));
    axr(ADDR_STATE);
    chk(rd[LOCK_LSB + c], 1'b1);
    axw(ADDR_PASSWORD, 32'(pw));
    cmd(CMD_UNLOCK, 8'h0);
    axr(ADDR_RESULT);
    chk(rd[15:8], ok ? ERR_NONE : ERR_NO_MATCH);
    axr(ADDR_STATE);
    chk(rd[LOCK_LSB + c], !ok);
    g = grants;
    cmd(CMD_PROTECTED_ACCESS, 8'h0);
    chk(grants - g, 32'(ok));
    if (ok) chk(lastScope, c);
  endtask

  initial begin
    reset = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, utilityRomActive} = '0;
    {awaddr, araddr, wdata, loaderPresent, applicationPresent} = '0;
    {blank, debugLockWord, wstrb} = {3'h7, 16'hFFFF, 4'hF};
    {num_errors, checks_done, erases, grants} = '0;
    {lastBase, lastScope} = '0;
    void'($urandom(32'h630f));
    for (int i = 0; i < 4; i++) begin
      boot(1'(i % 2), 1'(i / 2), 3'($urandom), i == 0 ? 16'hFFFF : 16'($urandom));
      cmd(READ_REGION_CONTEXT_CMD, 8'h0);
      axr(ADDR_RESULT);
      chk(rd[7:0], ctx);
    end
    boot(1'b1, 1'b1, 3'b010, 16'hFFFF);
    axw(ADDR_MASK, 32'h7);
    cmd(CMD_PROTECTED_ACCESS, 8'h0);
    axr(ADDR_RESULT);
    chk({rd[15:8], 24'(grants)}, {ERR_LOCKED, 24'h0});
    cmd(CMD_MASTER_ERASE, 8'h0);
    chk({lastBase, 30'(erases)}, {APPLICATION_REGION_CTX, 30'h1});
    for (int i = 0; i < 7; i++) begin
      v = i < 4 ? 8'(i) : 8'($urandom_range(255, 3));
      cmd(WRITE_REGION_CONTEXT_CMD, v);
      if (v < 3) ctx = v[1:0];
      cmd(CMD_STATUS, 8'h0);
      axr(ADDR_RESULT);
      chk(rd[7:0], v < 3 ? ERR_NONE : ERR_BAD_CONTEXT);
      cmd(CMD_MASTER_ERASE, 8'h0);
      chk(lastBase, ctx);
    end
    tryRegion(LOADER_REGION_CTX, '1, 1'b1);
    tryRegion(SYSTEM_REGION_CTX, PW_W'(16'h5A01), 1'b0);
    tryRegion(SYSTEM_REGION_CTX, PW_W'(16'h5A00), 1'b1);
    tryRegion(APPLICATION_REGION_CTX, PW_W'(16'h5A02), 1'b1);
    cmd(CMD_ERASE_SYSTEM, 8'h0);
    chk(lastBase, SYSTEM_REGION_CTX);
    cmd(CMD_ERASE_LOADER, 8'h0);
    chk(lastBase, LOADER_REGION_CTX);
    cmd(8'h77, 8'h0);
    axr(ADDR_RESULT);
    chk(rd[15:8], ERR_UNKNOWN_CMD);
    axw(ADDR_LOCK, 32'h7);
    axr(ADDR_STATE);
    chk(rd[6:4], 3'h4);
    utilityRomActive <= 1'b1;
    axw(ADDR_LOCK, 32'h3);
    axr(ADDR_STATE);
    chk(rd[6:4], 3'h3);
    chk(irq, 1'b1);
    axw(ADDR_STATUS, 32'h7);
    axr(ADDR_STATUS);
    chk({rd[2:0], irq}, 4'h0);
    axw(ADDR_MASK, 32'h0);
    cmd(CMD_STATUS, 8'h0);
    axr(ADDR_STATUS);
    chk({rd[2:0], irq}, 4'h2);
    axw(ADDR_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    axw(8'h40, 32'h0);
    chk(rs, AXI_SLVERR);
    axr(8'h40);
    chk({rd[29:0], rs}, {30'h0, AXI_SLVERR});
    complete_run();
  end

  // Whole run takes a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
